/* verilog/drc_pkg.sv */
// Constants, timing counts and types for the dynamic RAM host controller
package drc_pkg;

   // Clock and address layout
   localparam int CLK_PERIOD_NS = 4;
   localparam int ROW_W         = 7;
   localparam int COL_W         = 7;
   localparam int ADDR_W        = ROW_W + COL_W;
   localparam int CNT_W         = 8;

   // Times in ns; where grades differ the value suits both grades
   localparam int T_ASR_NS  = 4;    // Row address ahead of row strobe
   localparam int T_RAH_NS  = 35;
   localparam int T_RCD_NS  = 50;   // Inside both 25..65 and 35..85 windows
   localparam int T_RAS_NS  = 250;
   localparam int T_RAC_NS  = 250;
   localparam int T_CAC_NS  = 165;
   localparam int T_RP_NS   = 150;
   localparam int T_RC_NS   = 410;
   localparam int T_RWC_NS  = 475;
   localparam int T_WP_NS   = 75;
   localparam int T_RWL_NS  = 100;
   localparam int T_RRW_NS  = 305;
   localparam int T_REF_NS  = 2000000;

   // Least times rounded up to whole cycles
   localparam int ASR_CYC = (T_ASR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAH_CYC = (T_RAH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAC_CYC = (T_RAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAC_CYC = (T_CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RWC_CYC = (T_RWC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RWL_CYC = (T_RWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RRW_CYC = (T_RRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Points in the cycle counter, counted from the cycle start
   localparam int RAS_AT_I = ASR_CYC;
   localparam int COL_AT_I = RAS_AT_I + RAH_CYC;
   localparam int CAS_AT_I = RAS_AT_I + RCD_CYC;
   localparam int ACC_I    = (RAC_CYC > RCD_CYC + CAC_CYC) ?
                             RAC_CYC : RCD_CYC + CAC_CYC;
   localparam int SMP_AT_I = RAS_AT_I + ACC_I + 2;
   localparam int RD_END_I = SMP_AT_I + 1;
   localparam int WR_END_I = RAS_AT_I + RAS_CYC;
   localparam int MW_WE_I  = SMP_AT_I + 1;
   localparam int MW_LEAD  = (RWL_CYC > WP_CYC) ? RWL_CYC : WP_CYC;
   localparam int MW_END_A = MW_WE_I + MW_LEAD;
   localparam int MW_END_I = (MW_END_A > RAS_AT_I + RRW_CYC) ?
                             MW_END_A : RAS_AT_I + RRW_CYC;
   localparam int RF_END_I = WR_END_I;

   // Whole cycle: precharge after the strobes, and the least cycle time
   localparam int RD_TOT_I = (RD_END_I + RP_CYC > RAS_AT_I + RC_CYC) ?
                             RD_END_I + RP_CYC : RAS_AT_I + RC_CYC;
   localparam int WR_TOT_I = (WR_END_I + RP_CYC > RAS_AT_I + RC_CYC) ?
                             WR_END_I + RP_CYC : RAS_AT_I + RC_CYC;
   localparam int MW_TOT_I = (MW_END_I + RP_CYC > RAS_AT_I + RWC_CYC) ?
                             MW_END_I + RP_CYC : RAS_AT_I + RWC_CYC;
   localparam int RF_TOT_I = WR_TOT_I;

   localparam logic [CNT_W-1:0] RAS_AT = CNT_W'(RAS_AT_I);
   localparam logic [CNT_W-1:0] COL_AT = CNT_W'(COL_AT_I);
   localparam logic [CNT_W-1:0] CAS_AT = CNT_W'(CAS_AT_I);
   localparam logic [CNT_W-1:0] SMP_AT = CNT_W'(SMP_AT_I);
   localparam logic [CNT_W-1:0] MW_WE  = CNT_W'(MW_WE_I);
   localparam logic [CNT_W-1:0] WE_AT  = CNT_W'(COL_AT_I);
   localparam logic [CNT_W-1:0] RD_END = CNT_W'(RD_END_I);
   localparam logic [CNT_W-1:0] WR_END = CNT_W'(WR_END_I);
   localparam logic [CNT_W-1:0] MW_END = CNT_W'(MW_END_I);
   localparam logic [CNT_W-1:0] RF_END = CNT_W'(RF_END_I);
   localparam logic [CNT_W-1:0] RD_TOT = CNT_W'(RD_TOT_I);
   localparam logic [CNT_W-1:0] WR_TOT = CNT_W'(WR_TOT_I);
   localparam logic [CNT_W-1:0] MW_TOT = CNT_W'(MW_TOT_I);
   localparam logic [CNT_W-1:0] RF_TOT = CNT_W'(RF_TOT_I);

   // Refresh: one row every REF period / rows, less the longest cycle
   localparam int REF_ROWS      = 64;
   localparam int REF_ROW_W     = 6;
   localparam int REF_TIMER_W   = 16;
   localparam int REF_EVERY_CYC = T_REF_NS / REF_ROWS / CLK_PERIOD_NS
                                  - MW_TOT_I;
   localparam logic [3:0] INIT_REFRESHES = 4'h8;

   // Operations and controller states
   typedef enum logic [1:0] {
      OP_READ    = 2'h0,
      OP_WRITE   = 2'h1,
      OP_RMW     = 2'h2,
      OP_REFRESH = 2'h3
   } drc_op_t;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'h1,
      ST_STROBE    = 3'h2,
      ST_PRECHARGE = 3'h4
   } drc_state_t;

endpackage

/* verilog/drc_host.sv */
// Host-side cycle sequencer for a multiplexed-address one-bit dynamic RAM
// Notes on behaviour
// - Column strobe stays high at least 25 ns between low periods.
// - Column strobe may rise at most 20 ns after row strobe falls.
// - Column strobe falls within the row-to-column delay window.
// - Read and refresh cycles start no closer than the read cycle time.
// - Write cycles are spaced by at least the write cycle time.
// - Write strobe stays low for at least its pulse width.
// - Write strobe falls at least its lead time before row strobe rises.
// - Write strobe falls at least its lead time before column rises.
// - Read-modify-write keeps row strobe low within its pulse window.
// - Read-modify-write keeps column strobe low its minimum width.
// - All 64 rows are refreshed within each 2 ms period.
// - Eight refresh cycles run after reset before requests are taken.
`timescale 1ns/10ps
`default_nettype none

module drc_host
   import drc_pkg::*;
#(
   parameter int          REFRESH_EVERY = REF_EVERY_CYC,
   parameter logic        REFRESH_HALF  = 1'b0
) (
   // Clock, reset and freeze
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              clkEnable,
   // User request
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire logic [1:0]        reqOp,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic              reqWriteData,
   // User answer and status
   output logic                   rspValid,
   output logic                   rspData,
   output logic                   initDone,
   // RAM pins
   output logic                   rowStrobeN,
   output logic                   colStrobeN,
   output logic                   writeStrobeN,
   output logic [ROW_W-1:0]       muxedAddress,
   output logic                   ramDataIn,
   input  wire logic              ramDataOut
);

   drc_state_t             state;
   drc_state_t             next_state;
   drc_op_t                op;
   logic [CNT_W-1:0]       count;
   logic [CNT_W-1:0]       next_count;
   logic [ROW_W-1:0]       rowReg;
   logic [COL_W-1:0]       colReg;
   logic                   writeBit;
   logic [REF_ROW_W-1:0]   refreshRow;
   logic [REF_TIMER_W-1:0] refTimer;
   logic                   refreshPending;
   logic [3:0]             initLeft;

   wire logic                   isIdle     = (state == ST_IDLE);
   wire logic                   isStrobe   = (state == ST_STROBE);
   wire logic                   isPrech    = (state == ST_PRECHARGE);
   wire logic                   initBusy   = (initLeft != 4'h0);
   wire logic                   needRefresh = refreshPending | initBusy;
   wire logic                   startRef   = clkEnable & isIdle & needRefresh;
   wire logic                   accept     = reqValid & reqReady;
   wire logic                   refTick    = (refTimer == '0);
   wire logic                   userIsRef  = (reqOp == OP_REFRESH);
   wire logic [REF_TIMER_W-1:0] refReload  = REF_TIMER_W'(REFRESH_EVERY - 1);

   // Ready only when idle, initialised and no refresh owed
   assign reqReady = clkEnable & isIdle & ~needRefresh;

   // Strobe end and whole-cycle length per operation
   wire logic [CNT_W-1:0] endAt =
      (op == OP_READ)  ? RD_END :
      (op == OP_WRITE) ? WR_END :
      (op == OP_RMW)   ? MW_END : RF_END;
   wire logic [CNT_W-1:0] totalAt =
      (op == OP_READ)  ? RD_TOT :
      (op == OP_WRITE) ? WR_TOT :
      (op == OP_RMW)   ? MW_TOT : RF_TOT;

   // Pin decode; strobes rise together, so the column never trails the row
   wire logic rasLow = isStrobe & (count >= RAS_AT);
   wire logic casLow = isStrobe & (op != OP_REFRESH)
                       & (count >= CAS_AT);
   wire logic weEarly = (op == OP_WRITE) & (count >= WE_AT);
   wire logic weLate  = (op == OP_RMW) & (count >= MW_WE);
   wire logic weLow  = isStrobe & (weEarly | weLate);
   wire logic colSel = isStrobe & (count >= COL_AT);
   wire logic [ROW_W-1:0] addrNow = colSel ? colReg : rowReg;
   wire logic readsData = (op == OP_READ) | (op == OP_RMW);
   // Sample after both access times have run out, while column still low
   wire logic sampleNow = clkEnable & isStrobe & readsData
                          & (count == SMP_AT);

   // Sequencer: one counter runs from cycle start to end of precharge
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         ST_IDLE: begin
            if (startRef | accept) begin
               next_state = ST_STROBE;
               next_count = '0;
            end
         end
         ST_STROBE: begin
            next_count = count + CNT_W'(1);
            if (count == endAt) begin
               next_state = ST_PRECHARGE;
            end
         end
         ST_PRECHARGE: begin
            // Precharge also covers the output turn-off delay
            next_count = count + CNT_W'(1);
            if (count == totalAt) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_count = '0;
         end
      endcase
   end

   // State and counter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         count <= '0;
      end else if (clkEnable) begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Capture of the operation; refresh takes the next row in turn
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op       <= OP_REFRESH;
         rowReg   <= '0;
         colReg   <= '0;
         writeBit <= 1'b0;
      end else if (startRef) begin
         op     <= OP_REFRESH;
         rowReg <= {REFRESH_HALF, refreshRow};
      end else if (accept) begin
         op       <= drc_op_t'(reqOp);
         rowReg   <= userIsRef ? {REFRESH_HALF, refreshRow}
                               : reqAddr[ADDR_W-1:COL_W];
         colReg   <= reqAddr[COL_W-1:0];
         writeBit <= reqWriteData;
      end
   end

   // Refresh timer; a tick wins over the clear of a taken refresh
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         refTimer       <= '0;
         refreshPending <= 1'b0;
         refreshRow     <= '0;
      end else if (clkEnable) begin
         refTimer       <= refTick ? refReload : refTimer - REF_TIMER_W'(1);
         refreshPending <= refTick | (refreshPending & ~startRef);
         if (startRef | (accept & userIsRef)) begin
            refreshRow <= refreshRow + REF_ROW_W'(1);
         end
      end
   end

   // Start-up refresh burst; timer keeps row strobe from idling 2 ms
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         initLeft <= INIT_REFRESHES;
         initDone <= 1'b0;
      end else if (clkEnable) begin
         if (startRef & initBusy) begin
            initLeft <= initLeft - 4'h1;
         end
         initDone <= ~initBusy & isIdle;
      end
   end

   // Registered pins; idle leaves every strobe high
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rowStrobeN   <= 1'b1;
         colStrobeN   <= 1'b1;
         writeStrobeN <= 1'b1;
         muxedAddress <= '0;
         ramDataIn    <= 1'b0;
      end else if (clkEnable) begin
         rowStrobeN   <= ~rasLow;
         colStrobeN   <= ~casLow;
         writeStrobeN <= ~weLow;
         muxedAddress <= addrNow;
         ramDataIn    <= writeBit;
      end
   end

   // Read answer, a one-cycle pulse
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rspValid <= 1'b0;
         rspData  <= 1'b0;
      end else if (clkEnable) begin
         rspValid <= sampleNow;
         if (sampleNow) begin
            rspData <= ramDataOut;
         end
      end
   end

endmodule

`default_nettype wire

/* dv/drc_ram_model.sv */
// Behavioural one-bit dynamic RAM standing behind the host controller
`timescale 1ns/10ps
`default_nettype none
module drc_ram_model (
   // Strobes, address and data
   input  wire logic       rowStrobeN,
   input  wire logic       colStrobeN,
   input  wire logic       writeStrobeN,
   input  wire logic [6:0] muxedAddress,
   input  wire logic       ramDataIn,
   output logic            ramDataOut
);
   logic       mem [16384];
   logic [6:0] row;
   realtime    tRas;
   realtime    dly;
   // Row taken on the row strobe fall; a row-only refresh needs no more
   always @(negedge rowStrobeN) begin
      row = muxedAddress;
      tRas = $realtime;
   end
   // Early write stores at once; a read shows data at the later bound
   always @(negedge colStrobeN) begin
      dly = (tRas + 250 > $realtime + 165) ? tRas + 250 - $realtime : 165;
      if (!writeStrobeN)
         mem[{row, muxedAddress}] = ramDataIn;
      else begin
         // Wrong bit until the access time, so an early sample fails
         ramDataOut <= ~mem[{row, muxedAddress}];
         ramDataOut <= #(dly) mem[{row, muxedAddress}];
      end
   end
   // Write strobe falling under a low column strobe is a late write
   always @(negedge writeStrobeN)
      if (!colStrobeN)
         mem[{row, muxedAddress}] = ramDataIn;
   // No pull resistor: the floated line shows the inverse, not stale data
   always @(posedge colStrobeN)
      ramDataOut <= #70 ~ramDataOut;
   initial ramDataOut = 1'b0;
endmodule
`default_nettype wire

/* dv/drc_host_sva.sv */
// Strobe timing checker for the dynamic RAM host controller
`timescale 1ns/10ps
`default_nettype none
module drc_host_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // RAM strobes
   input wire logic rowStrobeN,
   input wire logic colStrobeN,
   input wire logic writeStrobeN
);
   logic [11:0] rasCnt, casCnt, hiCnt, cycCnt, weAge;
   logic        rasQ, weQ;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Widths in cycles; ages saturate so a long idle never wraps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {rasCnt, casCnt} <= 24'h0;
         {hiCnt, cycCnt, weAge} <= '1;
         {rasQ, weQ} <= 2'h3;
      end else begin
         rasQ <= rowStrobeN;
         weQ <= writeStrobeN;
         rasCnt <= rowStrobeN ? 12'h0 : rasCnt + 12'h1;
         casCnt <= colStrobeN ? 12'h0 : casCnt + 12'h1;
         hiCnt <= !rowStrobeN ? 12'h0 : hiCnt + {11'h0, ~&hiCnt};
         cycCnt <= (!rowStrobeN && rasQ) ? 12'h1
                   : cycCnt + {11'h0, ~&cycCnt};
         weAge <= (!writeStrobeN && weQ) ? 12'h1
                  : weAge + {11'h0, ~&weAge};
      end
   end
   chk_ras_cas_delay: assert property ($fell(colStrobeN) |->
      rasCnt inside {[9:16]}) else $error("column strobe delay off");
   chk_cas_precharge: assert property ($rose(colStrobeN) |=>
      colStrobeN[*7]) else $error("column strobe high too short");
   chk_cas_rise_late: assert property ($fell(rowStrobeN) |->
      ##[0:5] colStrobeN) else $error("column strobe rose too late");
   chk_ras_width: assert property ($rose(rowStrobeN) |->
      rasCnt inside {[63:2499]}) else $error("row strobe width off");
   chk_ras_precharge: assert property ($fell(rowStrobeN) |->
      hiCnt >= 12'h026) else $error("row precharge too short");
   chk_cycle_spacing: assert property ($fell(rowStrobeN) |->
      cycCnt >= 12'h067) else $error("cycles too close");
   chk_we_pulse: assert property ($rose(writeStrobeN) |->
      weAge >= 12'h013) else $error("write strobe too short");
   chk_we_ras_lead: assert property ($rose(rowStrobeN) |->
      weAge >= 12'h019) else $error("write lead to row too short");
   chk_we_cas_lead: assert property ($rose(colStrobeN) |->
      weAge >= 12'h019) else $error("write lead to column too short");
   chk_rmw_widths: assert property ($rose(rowStrobeN)
      && weAge < casCnt |-> rasCnt >= 12'h04d && casCnt >= 12'h03a)
      else $error("read-modify-write strobe too short");
endmodule
bind drc_host drc_host_sva chk_u (.clk(clk), .reset_n(reset_n),
   .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
   .writeStrobeN(writeStrobeN));
`default_nettype wire

/* dv/drc_host_test.sv */
// Self-checking bench for the dynamic RAM host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin failCount++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module drc_host_test
   import drc_pkg::*;
;
   logic              clk = 0, reset_n = 0, clkEnable = 1, reqValid = 0;
   logic              reqWriteData = 0, d;
   logic [1:0]        reqOp = 2'h0;
   logic [ADDR_W-1:0] reqAddr = '0;
   logic [ADDR_W-1:0] at [4] = '{14'h0000, 14'h3fff, 14'h2a55, 14'h1580};
   wire logic         reqReady, rspValid, rspData, initDone, ramDataOut;
   wire logic         rowStrobeN, colStrobeN, writeStrobeN, ramDataIn;
   wire logic [6:0]   muxedAddress;
   int                failCount = 0, nTests = 0, cycles = 0, i, k, f0;
   int                rasFalls = 0, casFalls = 0;
   drc_host #(.REFRESH_EVERY(400)) dut_u (.clk(clk), .reset_n(reset_n),
      .clkEnable(clkEnable), .reqValid(reqValid), .reqReady(reqReady),
      .reqOp(reqOp), .reqAddr(reqAddr), .reqWriteData(reqWriteData),
      .rspValid(rspValid), .rspData(rspData), .initDone(initDone),
      .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
      .writeStrobeN(writeStrobeN), .muxedAddress(muxedAddress),
      .ramDataIn(ramDataIn), .ramDataOut(ramDataOut));
   drc_ram_model ram_u (.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
      .writeStrobeN(writeStrobeN), .muxedAddress(muxedAddress),
      .ramDataIn(ramDataIn), .ramDataOut(ramDataOut));
   // Clock, strobe counts and hang guard
   always #2 clk = ~clk;
   always @(negedge rowStrobeN) rasFalls++;
   always @(negedge colStrobeN) casFalls++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (failCount == 0 && nTests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One request; read and RMW also return the bit and check its latency
   task automatic run(input logic [1:0] op, input int a, input logic w);
      reqOp <= op;
      reqAddr <= ADDR_W'(a);
      reqWriteData <= w;
      reqValid <= 1'b1;
      @(posedge clk);
      while (!reqReady) @(posedge clk);
      reqValid <= 1'b0;
      @(posedge clk);
      `CHK(reqReady, 1'b0)
      for (i = 1; op[0] == 1'b0 && rspValid !== 1'b1 && i < 80; i++)
         @(posedge clk);
      if (op[0] == 1'b0) `CHK(i inside {[67:69]}, 1'b1)
      d = rspData;
   endtask
   // Start-up refreshes are row-only and precede readiness
   task automatic t_init();
      `CHK({initDone, rowStrobeN, colStrobeN}, 3'h3)
      reset_n <= 1'b1;
      for (i = 0; i < 1500 && initDone !== 1'b1; i++) @(posedge clk);
      `CHK(initDone, 1'b1)
      `CHK(rasFalls >= 8, 1'b1)
      `CHK(casFalls, 0)
   endtask
   // Early writes then reads back at two corner and two other addresses, then late writes
   task automatic t_data();
      for (k = 0; k < 4; k++) run(2'h1, at[k], k[0] ^ 1'b1);
      for (k = 0; k < 4; k++) begin
         run(2'h0, at[k], 1'b0);
         `CHK(d, k[0] ^ 1'b1)
      end
      for (k = 1; k < 3; k++) begin
         run(2'h2, at[k], k[0]);
         `CHK(d, k[0] ^ 1'b1)
         run(2'h0, at[k], 1'b0);
         `CHK(d, k[0])
      end
   endtask
   // Refresh request, freeze, then idle refresh by the timer
   task automatic t_refresh();
      f0 = casFalls;
      run(2'h3, 0, 1'b0);
      clkEnable <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(reqReady, 1'b0)
      // Frozen before the row strobe falls, so the pin must still be high
      `CHK(rowStrobeN, 1'b1)
      clkEnable <= 1'b1;
      k = rasFalls;
      repeat (1300) @(posedge clk);
      `CHK(casFalls - f0, 0)
      `CHK(rasFalls - k >= 3, 1'b1)
   endtask
   initial begin
      repeat (10) @(posedge clk);
      t_init();
      t_data();
      t_refresh();
      wrap_up();
   end
endmodule
`default_nettype wire
